// [hdl/pmic_regs_params.svh]
`ifndef PMIC_REGS_PARAMS_SVH
`define PMIC_REGS_PARAMS_SVH

// ****************************************
// command codes
// ****************************************
`define CMD_REGULATOR_STATUS 8'h0b
`define CMD_EVENT_FLAGS 8'h0c
`define CMD_EVENT_MASK 8'h0d
`define CMD_LDO_MODE_AND_VOLTAGE 8'h0e

// ****************************************
// field positions
// ****************************************
`define BIT_BUCK_ONE 7
`define BIT_BUCK_TWO 6
`define BIT_THERMAL 5
`define BIT_LDO_GROUP 4
`define POWER_MODE_MSB 7
`define POWER_MODE_LSB 6
`define TARGET_VOLTAGE_MSB 5
`define TARGET_VOLTAGE_LSB 0

// ****************************************
// reset values and event field mask
// ****************************************
`define STATUS_RESET 8'hcf
`define FLAGS_RESET 8'h00
`define MASK_RESET 8'hf8
`define LDO_CONFIG_RESET 8'h00
`define EVENT_FIELD 8'hf0

// ****************************************
// target voltage scale in millivolts
// ****************************************
`define LDO_BASE_MV 12'h0320
`define LDO_STEP_MV 12'h0032

`endif

// [hdl/pmic_regs_pkg.sv]
package pmic_regs_pkg;

    // power mode field of the ldo configuration register
    typedef enum logic [1:0] {
        mode_off_low,
        mode_off_high,
        mode_green,
        mode_normal
    } power_mode_type;

    typedef logic [7:0] reg_byte_type;

endpackage : pmic_regs_pkg

// [hdl/ldo_mode_and_voltage.sv]
`timescale 1ns/1ps
`include "pmic_regs_params.svh"

module ldo_mode_and_voltage
    import pmic_regs_pkg::*;
(
    input wire logic clk, // 250 MHz clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic write_en, // one-cycle write of this register
    input wire logic [7:0] write_data, // byte to store
    output logic [7:0] config_value, // stored register, for read-back
    output power_mode_type regulator_power_mode, // mode field
    output logic [5:0] regulator_target_voltage, // voltage code field
    output logic ldo_output_enable, // output switched on
    output logic ldo_green_mode, // low quiescent mode
    output logic [11:0] target_millivolts // decoded voltage target
);

    // ****************************************
    // storage
    // ****************************************

    // plain read/write byte, only chip reset restores it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            config_value <= `LDO_CONFIG_RESET;
        end else if (write_en) begin
            config_value <= write_data;
        end
    end

    // ****************************************
    // field decode
    // ****************************************

    assign regulator_power_mode =
        power_mode_type'(config_value[`POWER_MODE_MSB:`POWER_MODE_LSB]);
    assign regulator_target_voltage = config_value[`TARGET_VOLTAGE_MSB:`TARGET_VOLTAGE_LSB];

    // both low codes mean disabled, so only the top bit turns the output on
    always_comb begin
        ldo_output_enable = 1'b0;
        ldo_green_mode = 1'b0;
        unique case (regulator_power_mode)
            mode_off_low, mode_off_high: ldo_output_enable = 1'b0;
            mode_green: begin
                ldo_output_enable = 1'b1;
                ldo_green_mode = 1'b1;
            end
            mode_normal: ldo_output_enable = 1'b1;
        endcase
    end

    // linear scale, largest code gives base plus 63 steps
    assign target_millivolts = 12'(`LDO_BASE_MV + `LDO_STEP_MV * {6'h00, regulator_target_voltage});

endmodule : ldo_mode_and_voltage

// [hdl/pmic_status_irq_ldo_regs.sv]
// Contract
// - status register is written only to restore defaults, tracks live state only where mask is clear
// - status bit 7 is 0 when buck one on, 1 when off or faulted
// - status bit 6 is 0 when buck two on, 1 when off or faulted
// - status bit 5 is 1 while die is over thermal shutdown threshold
// - status bit 4 is 1 while an enabled ldo is under power good
// - event bit 7 latches when buck one falls below power good; whole register clears on read
// - event bit 6 latches when buck two falls below power good
// - event bit 5 latches when die exceeds thermal shutdown threshold
// - event bit 4 latches when any ldo loses power good
// - mask bits 7 to 4 mask events when 1, default 1
// - reset restores defaults; writing 1 to a status, event or mask bit restores that bit; ldo config stores the byte
// - power mode 00/01 disabled, 10 green, 11 normal, default 00
`timescale 1ns/1ps
`include "pmic_regs_params.svh"

module pmic_status_irq_ldo_regs
    import pmic_regs_pkg::*;
(
    input wire logic clk, // 250 MHz clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [7:0] cmd_code, // command code of the access
    input wire logic cmd_write, // one-cycle write strobe
    input wire logic cmd_read, // one-cycle read strobe
    input wire logic [7:0] cmd_wdata, // write data byte
    output logic [7:0] cmd_rdata, // read data, held until next read
    output logic cmd_rvalid, // one-cycle pulse with read data
    input wire logic buck_one_on, // converter one regulating
    input wire logic buck_one_fault, // converter one faulted
    input wire logic buck_two_on, // converter two regulating
    input wire logic buck_two_fault, // converter two faulted
    input wire logic buck_one_below_good, // converter one under threshold
    input wire logic buck_two_below_good, // converter two under threshold
    input wire logic over_temperature, // die over shutdown threshold
    input wire logic ldo_group_below_good, // an enabled ldo under threshold
    output logic interrupt_request_n, // interrupt request, active low
    output power_mode_type regulator_power_mode, // ldo mode field
    output logic [5:0] regulator_target_voltage, // ldo voltage code
    output logic ldo_output_enable, // ldo output switched on
    output logic ldo_green_mode, // ldo in green mode
    output logic [11:0] target_millivolts // ldo target in mV
);

    // ****************************************
    // helpers
    // ****************************************

    // every bit written with 1 goes back to its default value
    function automatic reg_byte_type restore_bits(input reg_byte_type current,
                                                  input reg_byte_type ones,
                                                  input reg_byte_type dflt);
        restore_bits = (current & ~ones) | (dflt & ones);
    endfunction : restore_bits

    // ****************************************
    // access decode
    // ****************************************

    logic wr_status;
    logic wr_flags;
    logic wr_mask;
    logic wr_ldo;
    logic rd_flags;

    assign wr_status = cmd_write && (cmd_code == `CMD_REGULATOR_STATUS);
    assign wr_flags = cmd_write && (cmd_code == `CMD_EVENT_FLAGS);
    assign wr_mask = cmd_write && (cmd_code == `CMD_EVENT_MASK);
    assign wr_ldo = cmd_write && (cmd_code == `CMD_LDO_MODE_AND_VOLTAGE);
    assign rd_flags = cmd_read && (cmd_code == `CMD_EVENT_FLAGS);

    // ****************************************
    // live conditions
    // ****************************************

    logic [7:0] status_live;
    logic [7:0] event_live;

    // a faulted converter reads as not on even if its enable is high
    always_comb begin
        status_live = `STATUS_RESET;
        status_live[`BIT_BUCK_ONE] = !buck_one_on || buck_one_fault;
        status_live[`BIT_BUCK_TWO] = !buck_two_on || buck_two_fault;
        status_live[`BIT_THERMAL] = over_temperature;
        status_live[`BIT_LDO_GROUP] = ldo_group_below_good;
    end

    always_comb begin
        event_live = `FLAGS_RESET;
        event_live[`BIT_BUCK_ONE] = buck_one_below_good;
        event_live[`BIT_BUCK_TWO] = buck_two_below_good;
        event_live[`BIT_THERMAL] = over_temperature;
        event_live[`BIT_LDO_GROUP] = ldo_group_below_good;
    end

    // ****************************************
    // registers
    // ****************************************

    reg_byte_type regulator_status;
    reg_byte_type event_flags;
    reg_byte_type event_mask;
    reg_byte_type ldo_config;
    reg_byte_type next_status;
    reg_byte_type next_flags;

    // masked bits freeze; a host restore lasts one cycle before tracking resumes
    always_comb begin
        next_status = regulator_status;
        if (wr_status) begin
            next_status = restore_bits(regulator_status, cmd_wdata, `STATUS_RESET);
        end else begin
            next_status = (regulator_status & event_mask & `EVENT_FIELD)
                        | (status_live & ~event_mask & `EVENT_FIELD)
                        | (`STATUS_RESET & ~`EVENT_FIELD);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regulator_status <= `STATUS_RESET;
        end else begin
            regulator_status <= next_status;
        end
    end

    // set wins over read-clear so an event in the read cycle is kept
    always_comb begin
        next_flags = event_flags;
        if (rd_flags) begin
            next_flags = `FLAGS_RESET;
        end
        if (wr_flags) begin
            next_flags = restore_bits(next_flags, cmd_wdata, `FLAGS_RESET);
        end
        next_flags = next_flags | (event_live & `EVENT_FIELD);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            event_flags <= `FLAGS_RESET;
        end else begin
            event_flags <= next_flags;
        end
    end

    // mask bits 7 to 4 are stored as written, bits 3 to 0 hold default; writing 1 also equals its default
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            event_mask <= `MASK_RESET;
        end else if (wr_mask) begin
            event_mask <= (cmd_wdata & `EVENT_FIELD) | (`MASK_RESET & ~`EVENT_FIELD);
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************

    // open-drain style request: low while any unmasked event stands
    assign interrupt_request_n = !(|(event_flags & ~event_mask & `EVENT_FIELD));

    // ****************************************
    // ldo configuration
    // ****************************************

    ldo_mode_and_voltage ldo_cfg (
        .clk(clk),
        .rst_b(rst_b),
        .write_en(wr_ldo),
        .write_data(cmd_wdata),
        .config_value(ldo_config),
        .regulator_power_mode(regulator_power_mode),
        .regulator_target_voltage(regulator_target_voltage),
        .ldo_output_enable(ldo_output_enable),
        .ldo_green_mode(ldo_green_mode),
        .target_millivolts(target_millivolts)
    );

    // ****************************************
    // read path
    // ****************************************

    // data returns one cycle after the strobe; unknown codes read zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_rdata <= 8'h00;
        end else if (cmd_read) begin
            unique case (cmd_code)
                `CMD_REGULATOR_STATUS: cmd_rdata <= regulator_status;
                `CMD_EVENT_FLAGS: cmd_rdata <= event_flags;
                `CMD_EVENT_MASK: cmd_rdata <= event_mask;
                `CMD_LDO_MODE_AND_VOLTAGE: cmd_rdata <= ldo_config;
                default: cmd_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cmd_rvalid <= 1'b0;
        end else begin
            cmd_rvalid <= cmd_read;
        end
    end

    // ****************************************
    // checks
    // ****************************************

    buck_one_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!event_mask[`BIT_BUCK_ONE] && !wr_status)
        |=> regulator_status[`BIT_BUCK_ONE] == $past(!buck_one_on || buck_one_fault))
        else $error("buck one status does not follow converter state");

    buck_two_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!event_mask[`BIT_BUCK_TWO] && !wr_status)
        |=> regulator_status[`BIT_BUCK_TWO] == $past(!buck_two_on || buck_two_fault))
        else $error("buck two status does not follow converter state");

    thermal_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!event_mask[`BIT_THERMAL] && !wr_status)
        |=> regulator_status[`BIT_THERMAL] == $past(over_temperature))
        else $error("thermal status does not follow temperature");

    ldo_status_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!event_mask[`BIT_LDO_GROUP] && !wr_status)
        |=> regulator_status[`BIT_LDO_GROUP] == $past(ldo_group_below_good))
        else $error("ldo status does not follow power good");

    masked_status_hold_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_mask[`BIT_BUCK_ONE] && !wr_status) |=> $stable(regulator_status[`BIT_BUCK_ONE]))
        else $error("masked status bit changed");

    buck_one_event_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        buck_one_below_good |=> event_flags[`BIT_BUCK_ONE])
        else $error("buck one event not latched");

    read_clear_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_flags && !wr_flags && !(|event_live)) |=> event_flags == `FLAGS_RESET)
        else $error("event register not cleared by read");

    buck_two_event_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (buck_two_below_good && rd_flags) |=> event_flags[`BIT_BUCK_TWO])
        else $error("buck two event lost in read cycle");

    thermal_event_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(over_temperature) |=> event_flags[`BIT_THERMAL] [*1] ##0 !interrupt_request_n || event_mask[`BIT_THERMAL])
        else $error("thermal event not latched");

    ldo_event_hold_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (event_flags[`BIT_LDO_GROUP] && !rd_flags && !wr_flags) |=> event_flags[`BIT_LDO_GROUP])
        else $error("ldo event dropped without a read");

    mask_write_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_mask |=> event_mask[7:4] == $past(cmd_wdata[7:4]) && event_mask[3:0] == 4'h8)
        else $error("mask register not written");

    reset_default_a: assert property (
        @(posedge clk)
        !rst_b |=> regulator_status == `STATUS_RESET && event_flags == `FLAGS_RESET
                   && event_mask == `MASK_RESET && ldo_config == `LDO_CONFIG_RESET)
        else $error("register not at default after reset");

    mode_decode_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        ldo_output_enable == ldo_config[7] && ldo_green_mode == (ldo_config[7:6] == 2'b10))
        else $error("power mode decode wrong");

    voltage_scale_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_ldo |=> target_millivolts == 12'(800 + 50 * $past(cmd_wdata[5:0])))
        else $error("target voltage scale wrong");

    irq_assert_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (over_temperature && !event_mask[`BIT_THERMAL] && !wr_mask) |=> !interrupt_request_n)
        else $error("interrupt not raised for unmasked event");

    irq_release_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (rd_flags && !(|event_live) && !wr_flags) |=> interrupt_request_n)
        else $error("interrupt held after events cleared");

endmodule : pmic_status_irq_ldo_regs

// [sim/pmic_host_model.sv]
`timescale 1ns/1ps

module pmic_host_model (
    input wire logic clk, // bench clock
    input wire logic [7:0] cmd_rdata, // read byte from device
    input wire logic cmd_rvalid, // read answer pulse
    output logic [7:0] cmd_code, // command code
    output logic cmd_write, // write strobe
    output logic cmd_read, // read strobe
    output logic [7:0] cmd_wdata // write byte
);
    // idle code and write-data lines carry the inverse of the last value so stale data is never trusted; strobes idle low
    initial begin
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_wdata = 8'h00;
    end

    // one-cycle write strobe; a 1 written to a flag bit restores its default
    task automatic reg_write(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk);
        cmd_write <= 1'b1;
        cmd_code <= code;
        cmd_wdata <= data;
        @(posedge clk);
        cmd_write <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~data;
    endtask : reg_write

    // the answer is taken exactly one cycle after the strobe edge
    task automatic reg_read(input logic [7:0] code, output logic [7:0] data, output logic ok);
        @(posedge clk);
        cmd_read <= 1'b1;
        cmd_code <= code;
        @(posedge clk);
        cmd_read <= 1'b0;
        cmd_code <= ~code;
        @(posedge clk);
        ok = cmd_rvalid;
        data = cmd_rdata;
    endtask : reg_read
endmodule : pmic_host_model

// [sim/pmic_status_irq_ldo_regs_tb.sv]
`timescale 1ns/1ps
`include "pmic_regs_params.svh"

module pmic_status_irq_ldo_regs_tb;
    import pmic_regs_pkg::*;
    logic clk, rst_b, cmd_write, cmd_read, cmd_rvalid, irq_n, ldo_en, green, ok;
    logic b1_on, b1_flt, b2_on, b2_flt, b1_low, b2_low, hot, ldo_low;
    logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rd;
    logic [5:0] tv;
    logic [11:0] mv;
    power_mode_type pm;
    int fails, checked, cycles, mode;
    logic [5:0] codes [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};

    pmic_host_model host_u (.clk(clk), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata));

    pmic_status_irq_ldo_regs dut_u (.clk(clk), .rst_b(rst_b), .cmd_code(cmd_code),
        .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .buck_one_on(b1_on),
        .buck_one_fault(b1_flt), .buck_two_on(b2_on), .buck_two_fault(b2_flt),
        .buck_one_below_good(b1_low), .buck_two_below_good(b2_low),
        .over_temperature(hot), .ldo_group_below_good(ldo_low),
        .interrupt_request_n(irq_n), .regulator_power_mode(pm),
        .regulator_target_voltage(tv), .ldo_output_enable(ldo_en),
        .ldo_green_mode(green), .target_millivolts(mv));

    // ****************************************
    // checking and reporting
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic check12(input logic [11:0] got, input logic [11:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check12

    // a lost read answer counts as a mismatch too
    task automatic rd_check(input logic [7:0] code, input logic [7:0] exp);
        host_u.reg_read(code, rd, ok);
        check8({7'h00, ok}, 8'h01);
        check8(rd, exp);
    endtask : rd_check

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            test_done;
        end
    end

    // two-cycle pulse on one of the four event causes
    task automatic pulse(input int idx);
        @(posedge clk);
        {b1_low, b2_low, hot, ldo_low} <= 4'h8 >> idx;
        repeat (2) @(posedge clk);
        {b1_low, b2_low, hot, ldo_low} <= 4'h0;
        @(posedge clk);
    endtask : pulse

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        fails = 0;
        checked = 0;
        cycles = 0;
        rst_b = 1'b0;
        {b1_on, b1_flt, b2_on, b2_flt, b1_low, b2_low, hot, ldo_low} = 8'h00;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check8({7'h00, irq_n}, 8'h01);
        check12(mv, 12'h0320);
        rd_check(`CMD_REGULATOR_STATUS, 8'hcf);
        rd_check(`CMD_EVENT_FLAGS, 8'h00);
        rd_check(`CMD_EVENT_MASK, 8'hf8);
        rd_check(`CMD_LDO_MODE_AND_VOLTAGE, 8'h00);
        $display("test reset values done");

        // unmask all, then walk the status bits through their causes
        host_u.reg_write(`CMD_EVENT_MASK, 8'h00);
        rd_check(`CMD_EVENT_MASK, 8'h08);
        @(posedge clk);
        {b1_on, b2_on} <= 2'b11;
        rd_check(`CMD_REGULATOR_STATUS, 8'h0f);
        b1_flt <= 1'b1;
        rd_check(`CMD_REGULATOR_STATUS, 8'h8f);
        {b1_flt, b2_on} <= 2'b00;
        rd_check(`CMD_REGULATOR_STATUS, 8'h4f);
        {b2_on, b2_flt} <= 2'b11;
        rd_check(`CMD_REGULATOR_STATUS, 8'h4f);
        b2_flt <= 1'b0;
        {b2_on, hot} <= 2'b11;
        rd_check(`CMD_REGULATOR_STATUS, 8'h2f);
        check8({7'h00, irq_n}, 8'h00);
        {hot, ldo_low} <= 2'b01;
        rd_check(`CMD_REGULATOR_STATUS, 8'h1f);
        ldo_low <= 1'b0;
        rd_check(`CMD_EVENT_FLAGS, 8'h30);
        rd_check(`CMD_EVENT_FLAGS, 8'h00);
        check8({7'h00, irq_n}, 8'h01);
        $display("test status bits done");

        // each cause latches its own flag, cleared by one read
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            check8({7'h00, irq_n}, 8'h00);
            rd_check(`CMD_EVENT_FLAGS, 8'h80 >> i);
            rd_check(`CMD_EVENT_FLAGS, 8'h00);
        end
        $display("test event flags done");

        // a masked flag still latches but holds the request off
        host_u.reg_write(`CMD_EVENT_MASK, 8'hf0);
        rd_check(`CMD_EVENT_MASK, 8'hf8);
        pulse(2);
        check8({7'h00, irq_n}, 8'h01);
        host_u.reg_write(`CMD_EVENT_MASK, 8'hd0);
        @(posedge clk);
        check8({7'h00, irq_n}, 8'h00);
        host_u.reg_write(`CMD_EVENT_FLAGS, 8'h20);
        @(posedge clk);
        check8({7'h00, irq_n}, 8'h01);
        rd_check(`CMD_EVENT_FLAGS, 8'h00);
        // a frozen status bit written with 1 goes back to its default and stays there
        host_u.reg_write(`CMD_REGULATOR_STATUS, 8'h80);
        rd_check(`CMD_REGULATOR_STATUS, 8'h8f);
        $display("test mask and write-one done");

        // every power mode with a spread of voltage codes
        for (int i = 0; i < 4; i++) begin
            mode = i;
            host_u.reg_write(`CMD_LDO_MODE_AND_VOLTAGE, {mode[1:0], codes[i]});
            @(posedge clk);
            check8({6'h00, pm}, 8'(i));
            check8({6'h00, ldo_en, green}, {6'h00, mode[1], mode == 2});
            check8({2'h0, tv}, {2'h0, codes[i]});
            check12(mv, 12'(800 + 50 * codes[i]));
            rd_check(`CMD_LDO_MODE_AND_VOLTAGE, {mode[1:0], codes[i]});
        end
        $display("test ldo config done");

        // a second reset restores every default
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rd_check(`CMD_EVENT_MASK, 8'hf8);
        rd_check(`CMD_LDO_MODE_AND_VOLTAGE, 8'h00);
        // converters are on now, so a tracking status would not read its default
        rd_check(`CMD_REGULATOR_STATUS, 8'hcf);
        rd_check(`CMD_EVENT_FLAGS, 8'h00);
        check8({7'h00, irq_n}, 8'h01);
        rd_check(8'h7f, 8'h00);
        $display("test second reset done");
        test_done;
    end
endmodule : pmic_status_irq_ldo_regs_tb
